/* rtl/uart_line_pkg.sv */
/*
  Shared constants for the UART line-control block: flow modes, status
  selections, thresholds, infrared pulse window and timing figures.
  Assumes a single 20 MHz core clock and one UART channel per instance.
*/
package uart_line_pkg;

  // Core clock and activity toggle timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned ACT_TOGGLE_HZ   = 10;
  localparam int unsigned ACT_HALF_CYCLES = CLK_HZ / (2 * ACT_TOGGLE_HZ);

  // Flow control selection codes
  localparam logic [2:0] FLOW_NONE     = 3'h0;
  localparam logic [2:0] FLOW_HW       = 3'h1;
  localparam logic [2:0] FLOW_SW       = 3'h2;
  localparam logic [2:0] FLOW_MD_FREE  = 3'h3;
  localparam logic [2:0] FLOW_MD_GATED = 3'h4;

  // Receive FIFO level used when no watermark is programmed
  localparam int unsigned WATERMARK_DEFAULT = 450;

  // Status pin selections
  localparam logic [1:0] STAT_SUSPEND    = 2'h0;
  localparam logic [1:0] STAT_LOW_DRAW   = 2'h1;
  localparam logic [1:0] STAT_HOST_RESET = 2'h2;

  // Infrared pulse window in sixteenths of a bit
  localparam logic [3:0] IR_FIRST_3 = 4'h7;
  localparam logic [3:0] IR_FIRST_4 = 4'h6;
  localparam logic [3:0] IR_LAST    = 4'h9;

  // Values after reset
  localparam logic [3:0] PHASE_RESET = 4'h0;
  localparam logic [3:0] TURN_RESET  = 4'h0;

  // Transmit launch sequencing
  typedef enum logic [1:0] {TX_IDLE, TX_LAUNCH, TX_SHIFT} tx_state_t;

endpackage : uart_line_pkg

/* rtl/line_sync.sv */
/*
  Two-flop synchroniser for asynchronous level inputs.
  Assumes the inputs are plain levels; the first stage feeds only the second.
*/
`timescale 1ns/100ps
module line_sync #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_BIT = 1'h1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // Both stages reset to the idle level so a held line looks deasserted
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meta_ff  <= {W{RST_BIT}};
      sync_out <= {W{RST_BIT}};
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : line_sync

/* rtl/pair_buffer.sv */
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes the drain side may stall at any time; in_ready drops when full.
*/
`timescale 1ns/100ps
module pair_buffer #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);

  logic [W-1:0] mem_ff [2];
  logic         wr_ptr_ff;
  logic         rd_ptr_ff;
  logic [1:0]   cnt_ff;
  logic         push;
  logic         pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage needs no reset; only pointers and count carry control state
  always_ff @(posedge mclk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      cnt_ff <= 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule : pair_buffer

/* rtl/uart_line_flow_control.sv */
/*
  Line control around one UART channel: hardware and software flow control,
  multidrop address matching, half-duplex drive timing, infrared shaping,
  status pins, suspend pin handling and activity toggles.
  Assumes an outside shifter pair: the transmitter reports busy, the baud
  generator gives a bit tick and a 16x tick, the receiver gives one pulse per
  character with its mark bit (top data bit or parity) already decoded.
*/
// What this block does
// RL1 - RTS low while receive FIFO below 450 bytes, high once reached.
// RL2 - Remote deasserting CTS suspends our transmission; reassertion resumes it.
// RL3 - DTR/DSR selection makes DSR/DTR act exactly like CTS/RTS.
// RL4 - Received pause character halts transmit after current character completes.
// RL5 - Received resume character restarts transmission after a pause halt.
// RL6 - Send pause at watermark, resume below it; watermark replaces 450.
// RL7 - Multidrop address match needs mark bit set and match to either char.
// RL8 - After a match, address byte and following data go to FIFO.
// RL9 - Non-matching address byte disables the receiver.
// RL10 - Mode 3 transmits freely; mode 4 transmits only after address match.
// RL11 - Remote sender marks address bytes with mark bit, data with space.
// RL12 - Drive enable drops after last stop bit, optionally 1-15 bits later.
// RL13 - Half-duplex: receive input ignored while transmitter sends.
// RL14 - Infrared: centred 3/16 or 4/16 pulses, optional receive inversion, off at reset.
// RL15 - Two status pins, each picks one of three indications and polarity.
// RL16 - Low draw asserts in suspend, and before configuration for high-power parts.
// RL17 - Host reset indication asserted for the whole bus reset.
// RL18 - Suspend without override keeps pin outputs; with override uses sleep settings.
// RL19 - Suspend with override: clock pin low, drive enable deasserted.
// RL20 - Serial transmit and receive lines idle high during suspend.
// RL21 - Sleep level sets each pin; sleep drive picks open-drain or push-pull.
// RL22 - Activity toggles run near 10 Hz while their line is active.
// RL23 - Flow control asserts when FIFO count reaches the programmed watermark.
// RL24 - CTS and DSR inputs pass through two flip-flops before use.
`timescale 1ns/100ps
module uart_line_flow_control #(
  parameter int          CNT_W     = 10,
  parameter int          GPIO_N    = 10,
  parameter int unsigned ACT_HALF  = uart_line_pkg::ACT_HALF_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Configuration
  input  wire logic [2:0]        flow_mode,
  input  wire logic              pin_function_sel,
  input  wire logic              half_duplex_en,
  input  wire logic              auto_drive_en,
  input  wire logic [3:0]        turnaround_delay,
  input  wire logic              infrared_enable,
  input  wire logic              ir_wide_pulse,
  input  wire logic              ir_rx_invert,
  input  wire logic [CNT_W-1:0]  rx_watermark,
  input  wire logic [7:0]        resume_char_reg,
  input  wire logic [7:0]        pause_char_reg,
  // Baud timing and shifters
  input  wire logic              bit_tick,
  input  wire logic              sample_tick,
  input  wire logic              tx_busy,
  input  wire logic              tx_serial,
  output logic                   tx_shift_start,
  output logic      [7:0]        tx_shift_data,
  input  wire logic              tx_req_valid,
  input  wire logic [7:0]        tx_req_data,
  output logic                   tx_req_ready,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_mark,
  output logic                   rx_in_ready,
  output logic                   rx_out_valid,
  output logic      [7:0]        rx_out_data,
  input  wire logic              rx_out_ready,
  input  wire logic [CNT_W-1:0]  rx_fifo_count,
  // Serial pins
  output logic                   tx_pin_out,
  input  wire logic              rx_pin_in,
  output logic                   rx_line_out,
  output logic                   rts_n_out,
  input  wire logic              cts_n_in,
  output logic                   dtr_n_out,
  input  wire logic              dsr_n_in,
  output logic                   half_duplex_drive_enable,
  // USB state and status pins
  input  wire logic              usb_suspend,
  input  wire logic              usb_configured,
  input  wire logic              usb_bus_reset,
  input  wire logic              high_power_cfg,
  input  wire logic [3:0]        stat_sel,
  input  wire logic [1:0]        stat_invert,
  output logic      [1:0]        stat_out,
  // General pins
  input  wire logic [GPIO_N-1:0] gpio_out,
  input  wire logic [GPIO_N-1:0] gpio_oe,
  input  wire logic [GPIO_N-1:0] gpio_is_clock,
  input  wire logic              suspend_override_en,
  input  wire logic [GPIO_N-1:0] sleep_pin_level,
  input  wire logic [GPIO_N-1:0] sleep_pin_drive,
  output logic      [GPIO_N-1:0] gpio_pin_out,
  output logic      [GPIO_N-1:0] gpio_pin_oe,
  output logic                   tx_activity_toggle,
  output logic                   rx_activity_toggle
);

  localparam int AW = $clog2(ACT_HALF + 1);

  uart_line_pkg::tx_state_t state_ff;
  logic [1:0]       flow_n_s;
  logic             cts_off;
  logic             hw_mode;
  logic             sw_mode;
  logic             md_mode;
  logic [CNT_W-1:0] level;
  logic             at_level;
  logic             xoff_halt_ff;
  logic             paused_sent_ff;
  logic             match_ff;
  logic             need_pause;
  logic             need_resume;
  logic             tx_permit;
  logic             launch;
  logic             data_launch;
  logic             hd_blank;
  logic             addr_hit;
  logic             rx_store;
  logic             buf_in_valid;
  logic             de_ff;
  logic [3:0]       turn_cnt_ff;
  logic [3:0]       phase_ff;
  logic             ir_pulse;
  logic             susp_d_ff;
  logic [GPIO_N-1:0] hold_out_ff;
  logic [GPIO_N-1:0] hold_oe_ff;
  logic [AW-1:0]    act_cnt_ff;
  logic             act_tick;
  logic [1:0]       act_seen_ff;
  logic [1:0]       act_src;
  logic [1:0]       act_tog_ff;
  logic             low_draw;

  // Remote handshake inputs are asynchronous to mclk
  line_sync #(.W(2), .RST_BIT(1'h1)) u_flow_sync (  // [RL24]
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({dsr_n_in, cts_n_in}),
    .sync_out (flow_n_s)
  );

  // Mode decode and receive level; zero watermark keeps the default level
  assign hw_mode  = (flow_mode == uart_line_pkg::FLOW_HW);
  assign sw_mode  = (flow_mode == uart_line_pkg::FLOW_SW);
  assign md_mode  = (flow_mode == uart_line_pkg::FLOW_MD_FREE) || (flow_mode == uart_line_pkg::FLOW_MD_GATED);
  assign level    = (rx_watermark == '0) ? CNT_W'(uart_line_pkg::WATERMARK_DEFAULT) : rx_watermark;  // [RL6] [RL23]
  assign at_level = (rx_fifo_count >= level);  // [RL23]
  assign cts_off  = hw_mode && (pin_function_sel ? flow_n_s[1] : flow_n_s[0]);  // [RL2] [RL3]

  // Local request lines; the unused pair stays asserted
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rts_n_out <= 1'b0;
      dtr_n_out <= 1'b0;
    end
    else
    begin
      rts_n_out <= hw_mode && !pin_function_sel && at_level;  // [RL1]
      dtr_n_out <= hw_mode && pin_function_sel && at_level;   // [RL3]
    end
  end

  // Pause/resume characters owed to the remote end
  assign need_pause  = sw_mode && at_level && !paused_sent_ff;  // [RL6]
  assign need_resume = sw_mode && !at_level && paused_sent_ff;  // [RL6]

  // Gating only blocks new launches, so a character in flight always completes
  assign tx_permit = !cts_off && !(sw_mode && xoff_halt_ff) && !usb_suspend
                     && !((flow_mode == uart_line_pkg::FLOW_MD_GATED) && !match_ff);  // [RL2] [RL4] [RL10]
  assign launch      = (state_ff == uart_line_pkg::TX_IDLE) && !tx_busy
                       && !usb_suspend && (need_pause || need_resume || (tx_permit && tx_req_valid));
  assign data_launch = launch && !need_pause && !need_resume;
  assign tx_req_ready   = data_launch;
  assign tx_shift_start = launch;

  // Launch sequencing: wait for the shifter to take the byte and finish it
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state_ff <= uart_line_pkg::TX_IDLE;
    else
    begin
      case (state_ff)
        uart_line_pkg::TX_IDLE:   if (launch) state_ff <= uart_line_pkg::TX_LAUNCH;
        uart_line_pkg::TX_LAUNCH: if (tx_busy) state_ff <= uart_line_pkg::TX_SHIFT;
        uart_line_pkg::TX_SHIFT:  if (!tx_busy) state_ff <= uart_line_pkg::TX_IDLE;
        default:                  state_ff <= uart_line_pkg::TX_IDLE;
      endcase
    end
  end

  // Byte handed to the shifter, flow characters first
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tx_shift_data <= 8'h00;
    else if (launch)
      tx_shift_data <= need_pause ? pause_char_reg : (need_resume ? resume_char_reg : tx_req_data);  // [RL6]
  end

  // Record which flow character was last sent
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !sw_mode)
      paused_sent_ff <= 1'b0;
    else if (launch && need_pause)
      paused_sent_ff <= 1'b1;  // [RL6]
    else if (launch && need_resume)
      paused_sent_ff <= 1'b0;  // [RL6]
  end

  // Receive qualification: half-duplex blanking, flow chars, address filter
  assign hd_blank = half_duplex_en && tx_busy;  // [RL13]
  assign addr_hit = rx_mark && ((rx_data == resume_char_reg) || (rx_data == pause_char_reg));  // [RL7]
  always_comb
  begin
    rx_store = 1'b0;
    if (rx_valid && !hd_blank)
    begin
      if (sw_mode)
        rx_store = (rx_data != pause_char_reg) && (rx_data != resume_char_reg);
      else if (md_mode)
        rx_store = rx_mark ? addr_hit : match_ff;  // [RL8] [RL9]
      else
        rx_store = 1'b1;
    end
  end
  assign buf_in_valid = rx_store;

  // Remote pause state from received characters
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !sw_mode)
      xoff_halt_ff <= 1'b0;
    else if (rx_valid && !hd_blank && rx_data == pause_char_reg)
      xoff_halt_ff <= 1'b1;  // [RL4]
    else if (rx_valid && !hd_blank && rx_data == resume_char_reg)
      xoff_halt_ff <= 1'b0;  // [RL5]
  end

  // Address match state; any address byte re-decides it
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !md_mode)
      match_ff <= 1'b0;
    else if (rx_valid && !hd_blank && rx_mark)
      match_ff <= addr_hit;  // [RL7] [RL9] [RL11]
  end

  // Two entries absorb a receiver word while the FIFO side stalls
  pair_buffer #(.W(8)) u_rx_buf (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (buf_in_valid),
    .in_data   (rx_data),
    .in_ready  (rx_in_ready),
    .out_valid (rx_out_valid),
    .out_data  (rx_out_data),
    .out_ready (rx_out_ready)
  );

  // Drive enable held for the turnaround delay after the last stop bit
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      de_ff       <= 1'b0;
      turn_cnt_ff <= uart_line_pkg::TURN_RESET;
    end
    else if (tx_busy)
    begin
      de_ff       <= 1'b1;
      turn_cnt_ff <= turnaround_delay;
    end
    else if (de_ff && turn_cnt_ff == 4'h0)
      de_ff <= 1'b0;  // [RL12]
    else if (de_ff && bit_tick)
      turn_cnt_ff <= 4'(turn_cnt_ff - 4'h1);  // [RL12]
  end
  assign half_duplex_drive_enable = auto_drive_en && de_ff && !(usb_suspend && suspend_override_en);  // [RL19]

  // Sixteenth-of-bit phase, realigned at every bit boundary
  always_ff @(posedge mclk)
  begin
    if (!rst_n || bit_tick)
      phase_ff <= uart_line_pkg::PHASE_RESET;
    else if (sample_tick)
      phase_ff <= 4'(phase_ff + 4'h1);
  end
  assign ir_pulse = !tx_serial && (phase_ff <= uart_line_pkg::IR_LAST)
                    && (phase_ff >= (ir_wide_pulse ? uart_line_pkg::IR_FIRST_4 : uart_line_pkg::IR_FIRST_3));  // [RL14]

  // Serial pins; suspend forces both to idle high
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tx_pin_out  <= 1'b1;
      rx_line_out <= 1'b1;
    end
    else if (usb_suspend)
    begin
      tx_pin_out  <= 1'b1;  // [RL20]
      rx_line_out <= 1'b1;  // [RL20]
    end
    else
    begin
      tx_pin_out  <= infrared_enable ? ir_pulse : tx_serial;  // [RL14]
      rx_line_out <= hd_blank ? 1'b1 : ((infrared_enable && ir_rx_invert) ? ~rx_pin_in : rx_pin_in);  // [RL13] [RL14]
    end
  end

  // Status indications; low draw equals suspend for low-power parts
  assign low_draw = usb_suspend || (high_power_cfg && !usb_configured);  // [RL16]
  for (genvar s = 0; s < 2; s++)
  begin : g_stat
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        stat_out[s] <= stat_invert[s];
      else
      begin
        case (stat_sel[2*s +: 2])
          uart_line_pkg::STAT_SUSPEND:    stat_out[s] <= usb_suspend ^ stat_invert[s];    // [RL15]
          uart_line_pkg::STAT_LOW_DRAW:   stat_out[s] <= low_draw ^ stat_invert[s];       // [RL16]
          uart_line_pkg::STAT_HOST_RESET: stat_out[s] <= usb_bus_reset ^ stat_invert[s];  // [RL17]
          default:                        stat_out[s] <= stat_invert[s];
        endcase
      end
    end
  end

  // Pin state captured on suspend entry so it can be kept
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      susp_d_ff   <= 1'b0;
      hold_out_ff <= '0;
      hold_oe_ff  <= '0;
    end
    else
    begin
      susp_d_ff <= usb_suspend;
      if (!susp_d_ff)
      begin
        hold_out_ff <= gpio_out;
        hold_oe_ff  <= gpio_oe;
      end
    end
  end

  // General pins per bit; a set sleep_pin_drive bit means open-drain
  for (genvar g = 0; g < GPIO_N; g++)
  begin : g_pin
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        gpio_pin_out[g] <= 1'b0;
        gpio_pin_oe[g]  <= 1'b0;
      end
      else if (!usb_suspend)
      begin
        gpio_pin_out[g] <= gpio_out[g];
        gpio_pin_oe[g]  <= gpio_oe[g];
      end
      else if (!suspend_override_en)
      begin
        gpio_pin_out[g] <= hold_out_ff[g];  // [RL18]
        gpio_pin_oe[g]  <= hold_oe_ff[g];   // [RL18]
      end
      else if (gpio_is_clock[g])
      begin
        gpio_pin_out[g] <= 1'b0;  // [RL19]
        gpio_pin_oe[g]  <= 1'b1;  // [RL19]
      end
      else
      begin
        gpio_pin_out[g] <= sleep_pin_drive[g] ? 1'b0 : sleep_pin_level[g];  // [RL21]
        gpio_pin_oe[g]  <= sleep_pin_drive[g] ? !sleep_pin_level[g] : 1'b1;  // [RL18] [RL21]
      end
    end
  end

  // Activity window divider; one enable pulse each half period
  assign act_tick = (act_cnt_ff == AW'(ACT_HALF - 1));
  always_ff @(posedge mclk)
  begin
    if (!rst_n || act_tick)
      act_cnt_ff <= '0;
    else
      act_cnt_ff <= AW'(act_cnt_ff + 1'b1);
  end

  // Toggle at window end if the line saw activity; new activity beats the clear
  assign act_src = {rx_valid || !rx_pin_in, tx_busy};
  for (genvar a = 0; a < 2; a++)
  begin : g_act
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        act_seen_ff[a] <= 1'b0;
        act_tog_ff[a]  <= 1'b0;
      end
      else
      begin
        act_seen_ff[a] <= act_src[a] || (act_seen_ff[a] && !act_tick);
        if (act_tick && act_seen_ff[a])
          act_tog_ff[a] <= ~act_tog_ff[a];  // [RL22]
      end
    end
  end
  assign tx_activity_toggle = act_tog_ff[0];
  assign rx_activity_toggle = act_tog_ff[1];

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_drain_start;
    $fell(tx_busy) && turnaround_delay == 4'h0;
  endsequence
  sequence s_pause_seen;
    sw_mode && rx_valid && !hd_blank && rx_data == pause_char_reg && rx_data != resume_char_reg;
  endsequence

  chk_rts_level: assert property (hw_mode && !pin_function_sel && at_level |=> rts_n_out)  // [RL1]
    else $error("request line not raised at level");
  chk_dtr_level: assert property (hw_mode && pin_function_sel && !at_level |=> !dtr_n_out)  // [RL3]
    else $error("ready line not asserted below level");
  chk_cts_stall: assert property (hw_mode && !pin_function_sel && $past(cts_n_in, 2) |-> !data_launch)  // [RL2]
    else $error("data launched while remote not ready");
  chk_pause_halts: assert property (s_pause_seen |=> !data_launch [*2])  // [RL4]
    else $error("data launched after pause character");
  chk_resume_clear: assert property (sw_mode && xoff_halt_ff && rx_valid && !hd_blank
                                     && rx_data == resume_char_reg |=> !xoff_halt_ff)  // [RL5]
    else $error("resume character did not clear halt");
  chk_pause_sent: assert property (need_pause && launch |=> tx_shift_data == $past(pause_char_reg) && paused_sent_ff)  // [RL6]
    else $error("pause character not sent");
  chk_addr_miss: assert property (md_mode && rx_valid && !hd_blank && rx_mark && !addr_hit |=> !match_ff)  // [RL9]
    else $error("receiver stayed enabled after foreign address");
  chk_gated_tx: assert property (flow_mode == uart_line_pkg::FLOW_MD_GATED && !match_ff |-> !data_launch)  // [RL10]
    else $error("gated mode sent before address match");
  chk_drive_drop: assert property (s_drain_start ##0 !usb_suspend |=> !de_ff)  // [RL12]
    else $error("drive enable not dropped after stop bit");
  chk_hd_blank: assert property (hd_blank |-> !buf_in_valid)  // [RL13]
    else $error("received byte kept while transmitting");
  chk_suspend_idle: assert property (usb_suspend [*2] |-> tx_pin_out && rx_line_out)  // [RL20]
    else $error("serial lines not idle in suspend");

endmodule : uart_line_flow_control

/* tb/tx_shifter_model.sv */
/*
  Transmit shifter stand-in: loads a byte one cycle after start, busy ten cycles.
  Assumes the block's start pulse with data registered one cycle later.
*/
`timescale 1ns/100ps
module tx_shifter_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            serial,
  output logic [7:0]      last
);
  logic       load_ff;
  logic [3:0] cnt_ff;
  // Frame timing; start, bits and stop lumped into ten cycles
  always_ff @(posedge mclk)
  begin
    load_ff <= start & rst_n;
    busy    <= rst_n & (load_ff | (busy & (cnt_ff != 4'h9)));
    cnt_ff  <= (busy && rst_n) ? cnt_ff + 4'h1 : 4'h0;
    if (load_ff)
      last <= data;
  end
  assign serial = busy ? last[cnt_ff[2:0]] : 1'b1; // Idles high between frames
endmodule : tx_shifter_model

/* tb/uart_line_flow_control_tb.sv */
/*
  Self-checking bench for the line-control block with a shifter model.
  Assumes inputs change at the falling edge and a short activity half period.
*/
`timescale 1ns/100ps
module uart_line_flow_control_tb;
  logic mclk, rst_n, pin_function_sel, half_duplex_en, auto_drive_en, infrared_enable, ir_wide_pulse;
  logic ir_rx_invert, bit_tick, sample_tick, tx_busy, tx_serial, tx_shift_start, tx_req_valid, tx_req_ready;
  logic rx_valid, rx_mark, rx_in_ready, rx_out_valid, rx_out_ready, tx_pin_out, rx_pin_in, rx_line_out;
  logic rts_n_out, cts_n_in, dtr_n_out, dsr_n_in, half_duplex_drive_enable, usb_suspend, usb_configured;
  logic usb_bus_reset, high_power_cfg, suspend_override_en, tx_activity_toggle, rx_activity_toggle;
  logic [2:0] flow_mode;
  logic [3:0] turnaround_delay, stat_sel, tk;
  logic [1:0] stat_invert, stat_out;
  logic [7:0] resume_char_reg, pause_char_reg, tx_shift_data, tx_req_data, rx_data, rx_out_data, last;
  logic [9:0] rx_watermark, rx_fifo_count, gpio_out, gpio_oe, gpio_is_clock, sleep_pin_level;
  logic [9:0] sleep_pin_drive, gpio_pin_out, gpio_pin_oe, wm, exq[$];
  int         fail_count, total_checks;
  logic [7:0] b;

  uart_line_flow_control #(.ACT_HALF(8)) uut (.*);
  tx_shifter_model shifter (.mclk(mclk), .rst_n(rst_n), .start(tx_shift_start), .data(tx_shift_data),
                            .busy(tx_busy), .serial(tx_serial), .last(last));

  always #25 mclk = ~mclk;
  // Baud ticks: sample every cycle, bit every sixteenth
  always @(negedge mclk)
  begin
    tk <= tk + 4'h1;
    bit_tick <= &tk;
  end

  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Offer one byte; sampled just before the edge since ready is combinational
  task automatic send(input logic [7:0] d, input bit take);
    bit got;
    got = 0;
    tx_req_valid = 1;
    tx_req_data = d;
    for (int i = 0; i < 30 && !got; i++)
    begin
      #20 got = tx_req_ready;
      @(negedge mclk);
    end
    tx_req_valid = 0;
    chk("tx_taken", take, got);
    for (int i = 0; i < 40 && got && (i < 3 || tx_busy); i++)
      @(negedge mclk);
    if (got)
      chk("tx_byte", d, last);
  endtask : send

  task automatic rx_char(input logic [7:0] d, input logic m, input bit st);
    rx_valid = 1;
    rx_data = d;
    rx_mark = m;
    if (st)
      exq.push_back({2'b00, d});
    @(negedge mclk);
    rx_valid = 0;
    repeat (3) @(negedge mclk);
  endtask : rx_char

  task automatic lvl(input logic [9:0] c, input logic [9:0] e, input logic [9:0] s, input string n);
    rx_fifo_count = c;
    repeat (3) @(negedge mclk);
    chk(n, e, pin_function_sel ? dtr_n_out : rts_n_out);
  endtask : lvl

  // Reference queue of stored characters, compared at each pop
  always @(posedge mclk)
    if (rx_out_valid === 1'b1)
      chk("rx_out_data", exq.size() ? exq.pop_front() : 10'h3FF, {2'b00, rx_out_data});

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    report_and_stop;
  end

  initial
  begin
    {mclk, rst_n, pin_function_sel, half_duplex_en, auto_drive_en, infrared_enable, ir_wide_pulse, ir_rx_invert,
     bit_tick, tx_req_valid, rx_valid, rx_mark, rx_pin_in, cts_n_in, dsr_n_in, usb_suspend, usb_configured,
     usb_bus_reset, high_power_cfg, suspend_override_en, flow_mode, turnaround_delay, stat_sel, tk, stat_invert,
     tx_req_data, rx_data, rx_watermark, rx_fifo_count, gpio_oe, gpio_is_clock, sleep_pin_level,
     sleep_pin_drive} = '0;
    {sample_tick, rx_out_ready, rx_pin_in} = 3'h7;
    resume_char_reg = 8'h11;
    pause_char_reg = 8'h13;
    void'($urandom(32'h858B67FA));
    gpio_out = 10'($urandom);
    repeat (3) @(negedge mclk);
    rst_n = 1;
    chk("rts_reset", 10'h000, rts_n_out);
    // Hardware flow levels, default and programmed watermark, both pin pairs
    flow_mode = uart_line_pkg::FLOW_HW;
    lvl(10'd449, 10'h000, 0, "rts_below");
    lvl(10'd450, 10'h001, 0, "rts_at");
    wm = 10'($urandom_range(500, 2));
    rx_watermark = wm;
    lvl(wm - 10'h1, 10'h000, 0, "rts_wm_below");
    lvl(wm, 10'h001, 0, "rts_wm_at");
    pin_function_sel = 1;
    lvl(wm, 10'h001, 0, "dtr_at");
    lvl(10'h000, 10'h000, 0, "dtr_below");
    pin_function_sel = 0;
    cts_n_in = 1;
    repeat (3) @(negedge mclk);
    b = 8'($urandom);
    send(b, 0);
    cts_n_in = 0;
    send(b, 1);
    // Software flow: owed characters, then halt and resume on receive
    flow_mode = uart_line_pkg::FLOW_SW;
    rx_watermark = 0;
    lvl(10'd450, 10'h000, 0, "hold");
    repeat (30) @(negedge mclk);
    chk("pause_sent", 10'h013, last);
    rx_fifo_count = 0;
    repeat (30) @(negedge mclk);
    chk("resume_sent", 10'h011, last);
    rx_char(8'h13, 0, 0);
    send(b, 0);
    rx_char(8'h11, 0, 0);
    send(~b, 1);
    // Multidrop: gated transmit needs a match; foreign address drops data
    flow_mode = uart_line_pkg::FLOW_MD_GATED;
    rx_char(8'hA5, 1, 0);
    rx_char(8'h13, 0, 0);
    send(b, 0);
    rx_char(8'h13, 1, 1);
    rx_char(b & 8'h7F, 0, 1);
    send(b, 1);
    rx_char(8'hA5, 1, 0);
    rx_char(8'h42, 0, 0);
    flow_mode = uart_line_pkg::FLOW_MD_FREE;
    send(b, 1);
    // Status pins: every selection asserted, then all released
    {usb_suspend, usb_bus_reset, high_power_cfg, stat_invert} = 5'h1E;
    for (int s = 0; s < 3; s++)
    begin
      stat_sel = {2'(s), 2'(s)};
      repeat (3) @(negedge mclk);
      chk("stat_on", 10'h001, stat_out);
      chk("tx_idle", 10'h001, tx_pin_out);
    end
    chk("gpio_keep", gpio_out, gpio_pin_out);
    {usb_suspend, usb_bus_reset, usb_configured} = 3'h1;
    repeat (3) @(negedge mclk);
    chk("stat_off", 10'h002, stat_out);
    chk("rx_left", 10'h000, 10'(exq.size()));
    report_and_stop;
  end
endmodule : uart_line_flow_control_tb
